// ==== src/pfr_pkg.sv ====
package pfr_pkg;

   // Two-bit function select codes of a pin control field.
   typedef enum logic [1:0] {
      PFR_MUX_GPIO  = 2'h0,
      PFR_MUX_ALT   = 2'h1,
      PFR_MUX_ALT2  = 2'h2,
      PFR_MUX_INPUT = 2'h3
   } pfr_mux_type;

   // Reset-out pad state taken on system reset: driven, low.
   localparam logic PFR_RST_OUT_PAD_RST  = 1'h0;
   localparam logic PFR_RST_OUT_OE_N_RST = 1'h0;

   // Level that an undriven open-drain or idle pin reads as.
   localparam logic PFR_PIN_IDLE = 1'h1;

   // Level that an open-drain pad drives while enabled.
   localparam logic PFR_OD_DRIVE = 1'h0;

   // Crisis recovery flag after power-on reset, before the strap is sampled.
   localparam logic PFR_CRISIS_RST = 1'h0;

   // Bit positions inside the keyboard-mouse pad group.
   localparam int PFR_PS2_A_CLK = 0;
   localparam int PFR_PS2_A_DAT = 1;
   localparam int PFR_PS2_B_CLK = 2;
   localparam int PFR_PS2_B_DAT = 3;

   // Flip-flop stages in front of logic for every pin input.
   localparam int PFR_SYNC_STAGES = 2;

endpackage : pfr_pkg

// ==== src/pfr_sync2.sv ====
`timescale 1ns/1ps
module pfr_sync2 #(
   parameter int         W        = 1,
   parameter logic [0:0] IDLE_VAL = 1'h1
) (
   input  wire logic         clk,
   input  wire logic         ce,
   input  wire logic         srst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } pfr_sync_type;

   pfr_sync_type r_r;
   pfr_sync_type r_nxt;

   // The first stage feeds the second and nothing else, so metastability stays contained.
   always_comb begin
      r_nxt = r_r;
      if (srst) begin
         r_nxt.s1 = {W{IDLE_VAL}};
         r_nxt.s2 = {W{IDLE_VAL}};
      end else begin
         r_nxt.s1 = d;
         r_nxt.s2 = r_r.s1;
      end
   end

   // Reset overrides the clock enable so a frozen block still comes out of reset clean.
   always_ff @(posedge clk) begin
      if (srst || ce) begin
         r_r <= r_nxt;
      end
   end

   assign q = r_r.s2;

endmodule : pfr_sync2

// ==== src/pfr_pin_function_routing.sv ====
`timescale 1ns/1ps
module pfr_pin_function_routing #(
   parameter int N_DBG  = 4,
   parameter int N_UART = 2,
   parameter int N_EMI  = 3,
   parameter int N_TWP  = 8,
   parameter int N_TWC  = 4,
   parameter int TWPW   = 3
) (
   input  wire logic                  clk,
   input  wire logic                  ce,
   input  wire logic                  srst,
   input  wire logic                  por_srst,
   input  wire logic                  debug_rst_n_pin,
   input  wire logic [N_DBG-1:0]      dbg_pad_in,
   input  wire logic [N_DBG-1:0]      dbg_core_out,
   input  wire logic [N_DBG-1:0]      dbg_core_oe_n,
   input  wire logic [N_DBG-1:0]      dbg_gpio_out,
   input  wire logic [N_DBG-1:0]      dbg_gpio_oe_n,
   input  wire logic [N_DBG-1:0]      dbg_alt_out,
   input  wire logic [N_DBG-1:0]      dbg_alt_oe_n,
   input  wire logic [2*N_DBG-1:0]    dbg_mux_sel,
   input  wire logic [3:0]            ps2_pad_in,
   input  wire logic [1:0]            ps2_a_mux_sel,
   input  wire logic [1:0]            ps2_b_mux_sel,
   input  wire logic                  ps2_clk_drive_low,
   input  wire logic                  ps2_dat_drive_low,
   input  wire logic                  rst_gpio_out,
   input  wire logic                  rst_gpio_oe_n,
   input  wire logic                  week_battery_general_output_sel,
   input  wire logic                  battery_general_output_value,
   input  wire logic                  battery_general_output_gpio_out,
   input  wire logic                  uart_clk_pin,
   input  wire logic [N_UART-1:0]     uart_ext_sel,
   input  wire logic [N_UART-1:0]     uart_int_tick,
   input  wire logic [N_EMI-1:0]      emi_irq_n,
   input  wire logic                  keyscan_recovery_strap,
   input  wire logic                  wake_input_n,
   input  wire logic [N_TWP-1:0]      tw_sda_pad_in,
   input  wire logic [N_TWP-1:0]      tw_scl_pad_in,
   input  wire logic [N_TWC*TWPW-1:0] tw_port_sel,
   input  wire logic [N_TWC-1:0]      tw_sda_drive_low,
   input  wire logic [N_TWC-1:0]      tw_scl_drive_low,
   input  wire logic                  cfg_power_protect,
   input  wire logic                  sci_hw_event,
   input  wire logic                  sci_fw_assert,
   output logic                       debug_routed,
   output logic      [N_DBG-1:0]      dbg_pad_out,
   output logic      [N_DBG-1:0]      dbg_pad_oe_n,
   output logic      [N_DBG-1:0]      dbg_core_in,
   output logic      [3:0]            ps2_pad_out,
   output logic      [3:0]            ps2_pad_oe_n,
   output logic                       ps2_core_clk,
   output logic                       ps2_core_dat,
   output logic                       rst_out_pad,
   output logic                       rst_out_oe_n,
   output logic                       battery_general_output_pad,
   output logic                       battery_general_output_vbat_sel,
   output logic      [N_UART-1:0]     uart_baud_tick,
   output logic                       merged_mailbox_irq_n,
   output logic                       crisis_recovery,
   output logic                       wake_core_n,
   output logic      [N_TWC-1:0]      tw_ctrl_sda_in,
   output logic      [N_TWC-1:0]      tw_ctrl_scl_in,
   output logic      [N_TWP-1:0]      tw_pad_out,
   output logic      [N_TWP-1:0]      tw_sda_oe_n,
   output logic      [N_TWP-1:0]      tw_scl_oe_n,
   output logic                       uart_vcc_protect,
   output logic                       controller_sci_n
);

   // Layout of the synchronised pin bus.
   localparam int P_DRST = 0;
   localparam int P_DBG  = 1;
   localparam int P_PS2  = P_DBG + N_DBG;
   localparam int P_UCLK = P_PS2 + 4;
   localparam int P_STRP = P_UCLK + 1;
   localparam int P_WAKE = P_STRP + 1;
   localparam int P_SDA  = P_WAKE + 1;
   localparam int P_SCL  = P_SDA + N_TWP;
   localparam int SW     = P_SCL + N_TWP;

   // Parameters that the mux and index logic cannot serve are refused.
   if (N_DBG < 1 || N_UART < 1 || N_EMI < 1 || N_TWC < 1 || N_TWP < 2
       || TWPW != $clog2(N_TWP)) begin : g_bad_param
      $error("pfr_pin_function_routing: unsupported parameter values");
   end

   typedef struct packed {
      logic              dbg_route;
      logic [N_DBG-1:0]  dbg_out;
      logic [N_DBG-1:0]  dbg_oe_n;
      logic [N_DBG-1:0]  dbg_in;
      logic [3:0]        ps2_out;
      logic [3:0]        ps2_oe_n;
      logic              ps2_clk;
      logic              ps2_dat;
      logic              rst_pad;
      logic              rst_oe_n;
      logic              battery_general_output;
      logic              vbat;
      logic [N_UART-1:0] baud;
      logic              uclk_prev;
      logic              mbox_n;
      logic              por_prev;
      logic              crisis;
      logic              wake_n;
      logic [N_TWC-1:0]  c_sda;
      logic [N_TWC-1:0]  c_scl;
      logic [N_TWP-1:0]  tw_out;
      logic [N_TWP-1:0]  sda_oe_n;
      logic [N_TWP-1:0]  scl_oe_n;
      logic              protect;
      logic              sci_n;
   } pfr_state_type;

   pfr_state_type st_r;
   pfr_state_type st_nxt;
   logic [SW-1:0] pin_s;

   // Field select for one controller out of the packed port-select bus.
   function automatic logic [TWPW-1:0] port_of(input logic [N_TWC*TWPW-1:0] sel, input int c);
      port_of = sel[c*TWPW +: TWPW];
   endfunction : port_of

   // A keyboard-mouse set belongs to the controller only under the alternate code.
   function automatic logic is_alt(input logic [1:0] sel);
      is_alt = (sel == pfr_pkg::PFR_MUX_ALT);
   endfunction : is_alt

   // Every pin-level input crosses into the clock domain before use.
   pfr_sync2 #(
      .W        (SW),
      .IDLE_VAL (pfr_pkg::PFR_PIN_IDLE)
   ) u_sync (
      .clk  (clk),
      .ce   (ce),
      .srst (srst),
      .d    ({tw_scl_pad_in, tw_sda_pad_in, wake_input_n, keyscan_recovery_strap,
              uart_clk_pin, ps2_pad_in, dbg_pad_in, debug_rst_n_pin}),
      .q    (pin_s)
   );

   // Next-state logic for all routing and status flops.
   always_comb begin
      logic a_sel;
      logic b_sel;
      logic ext_edge;
      logic [TWPW-1:0] p;
      st_nxt   = st_r;
      a_sel    = is_alt(ps2_a_mux_sel);
      b_sel    = is_alt(ps2_b_mux_sel);
      ext_edge = pin_s[P_UCLK] & ~st_r.uclk_prev;
      p        = '0;
      st_nxt.dbg_route = pin_s[P_DRST];
      for (int i = 0; i < N_DBG; i++) begin
         if (pin_s[P_DRST]) begin
            st_nxt.dbg_out[i]  = dbg_core_out[i];
            st_nxt.dbg_oe_n[i] = dbg_core_oe_n[i];
            st_nxt.dbg_in[i]   = pin_s[P_DBG+i];
         end else begin
            st_nxt.dbg_in[i] = pfr_pkg::PFR_PIN_IDLE;
            case (dbg_mux_sel[2*i +: 2])
               pfr_pkg::PFR_MUX_GPIO: begin
                  st_nxt.dbg_out[i]  = dbg_gpio_out[i];
                  st_nxt.dbg_oe_n[i] = dbg_gpio_oe_n[i];
               end
               pfr_pkg::PFR_MUX_ALT: begin
                  st_nxt.dbg_out[i]  = dbg_alt_out[i];
                  st_nxt.dbg_oe_n[i] = dbg_alt_oe_n[i];
               end
               default: begin
                  st_nxt.dbg_out[i]  = 1'h0;
                  st_nxt.dbg_oe_n[i] = 1'h1;
               end
            endcase
         end
      end
      // Unselected sets read idle, so a stray set cannot corrupt the shared controller.
      st_nxt.ps2_clk = (a_sel ? pin_s[P_PS2+pfr_pkg::PFR_PS2_A_CLK] : 1'h1)
                     & (b_sel ? pin_s[P_PS2+pfr_pkg::PFR_PS2_B_CLK] : 1'h1);
      st_nxt.ps2_dat = (a_sel ? pin_s[P_PS2+pfr_pkg::PFR_PS2_A_DAT] : 1'h1)
                     & (b_sel ? pin_s[P_PS2+pfr_pkg::PFR_PS2_B_DAT] : 1'h1);
      st_nxt.ps2_out = {4{pfr_pkg::PFR_OD_DRIVE}};
      st_nxt.ps2_oe_n[pfr_pkg::PFR_PS2_A_CLK] = ~(a_sel & ps2_clk_drive_low);
      st_nxt.ps2_oe_n[pfr_pkg::PFR_PS2_A_DAT] = ~(a_sel & ps2_dat_drive_low);
      st_nxt.ps2_oe_n[pfr_pkg::PFR_PS2_B_CLK] = ~(b_sel & ps2_clk_drive_low);
      st_nxt.ps2_oe_n[pfr_pkg::PFR_PS2_B_DAT] = ~(b_sel & ps2_dat_drive_low);
      // Reset-out is ordinary GPIO once firmware runs.
      st_nxt.rst_pad  = rst_gpio_out;
      st_nxt.rst_oe_n = rst_gpio_oe_n;
      st_nxt.vbat = week_battery_general_output_sel;
      st_nxt.battery_general_output = week_battery_general_output_sel ? battery_general_output_value : battery_general_output_gpio_out;
      // The external clock is sampled, so it must run well below half the core rate.
      st_nxt.uclk_prev = pin_s[P_UCLK];
      for (int u = 0; u < N_UART; u++) begin
         st_nxt.baud[u] = uart_ext_sel[u] ? ext_edge : uart_int_tick[u];
      end
      st_nxt.mbox_n  = &emi_irq_n;
      st_nxt.wake_n  = pin_s[P_WAKE];
      st_nxt.protect = cfg_power_protect;
      st_nxt.sci_n   = ~(sci_hw_event | sci_fw_assert);
      // Out-of-range port selects read idle and drive nothing.
      st_nxt.tw_out   = {N_TWP{pfr_pkg::PFR_OD_DRIVE}};
      st_nxt.sda_oe_n = '1;
      st_nxt.scl_oe_n = '1;
      for (int c = 0; c < N_TWC; c++) begin
         p = port_of(tw_port_sel, c);
         st_nxt.c_sda[c] = pfr_pkg::PFR_PIN_IDLE;
         st_nxt.c_scl[c] = pfr_pkg::PFR_PIN_IDLE;
         if (int'(p) < N_TWP) begin
            st_nxt.c_sda[c] = pin_s[P_SDA+int'(p)];
            st_nxt.c_scl[c] = pin_s[P_SCL+int'(p)];
            if (tw_sda_drive_low[c]) begin
               st_nxt.sda_oe_n[p] = 1'h0;
            end
            if (tw_scl_drive_low[c]) begin
               st_nxt.scl_oe_n[p] = 1'h0;
            end
         end
      end
      // Strap is taken on the first edge after power-on reset lets go.
      st_nxt.por_prev = por_srst;
      if (por_srst) begin
         st_nxt.crisis = pfr_pkg::PFR_CRISIS_RST;
      end else if (st_r.por_prev) begin
         st_nxt.crisis = ~pin_s[P_STRP];
      end
      if (srst) begin
         st_nxt.rst_pad  = pfr_pkg::PFR_RST_OUT_PAD_RST;
         st_nxt.rst_oe_n = pfr_pkg::PFR_RST_OUT_OE_N_RST;
         st_nxt.dbg_oe_n = '1;
         st_nxt.ps2_oe_n = '1;
         st_nxt.sda_oe_n = '1;
         st_nxt.scl_oe_n = '1;
         st_nxt.baud     = '0;
         st_nxt.vbat     = 1'h0;
         st_nxt.sci_n    = 1'h1;
      end
   end

   // A system reset keeps the crisis flag; only power-on reset clears it.
   always_ff @(posedge clk) begin
      if (srst || por_srst || ce) begin
         st_r <= st_nxt;
      end
   end

   assign debug_routed         = st_r.dbg_route;
   assign dbg_pad_out          = st_r.dbg_out;
   assign dbg_pad_oe_n         = st_r.dbg_oe_n;
   assign dbg_core_in          = st_r.dbg_in;
   assign ps2_pad_out          = st_r.ps2_out;
   assign ps2_pad_oe_n         = st_r.ps2_oe_n;
   assign ps2_core_clk         = st_r.ps2_clk;
   assign ps2_core_dat         = st_r.ps2_dat;
   assign rst_out_pad          = st_r.rst_pad;
   assign rst_out_oe_n         = st_r.rst_oe_n;
   assign battery_general_output_pad             = st_r.battery_general_output;
   assign battery_general_output_vbat_sel        = st_r.vbat;
   assign uart_baud_tick       = st_r.baud;
   assign merged_mailbox_irq_n = st_r.mbox_n;
   assign crisis_recovery      = st_r.crisis;
   assign wake_core_n          = st_r.wake_n;
   assign tw_ctrl_sda_in       = st_r.c_sda;
   assign tw_ctrl_scl_in       = st_r.c_scl;
   assign tw_pad_out           = st_r.tw_out;
   assign tw_sda_oe_n          = st_r.sda_oe_n;
   assign tw_scl_oe_n          = st_r.scl_oe_n;
   assign uart_vcc_protect     = st_r.protect;
   assign controller_sci_n     = st_r.sci_n;

   // Helper views for the checks below.
   logic            s_drst;
   logic            s_strap;
   logic [TWPW-1:0] sel0;
   logic            pick0;
   logic            gpio_all;
   assign s_drst   = pin_s[P_DRST];
   assign s_strap  = pin_s[P_STRP];
   assign sel0     = port_of(tw_port_sel, 0);
   assign pick0    = (int'(sel0) < N_TWP) ? pin_s[P_SDA+int'(sel0)] : pfr_pkg::PFR_PIN_IDLE;
   assign gpio_all = (dbg_mux_sel == '0);

   default clocking cb @(posedge clk); endclocking
   default disable iff (srst || por_srst);

   a_dbg_route_follow: assert property ($past(ce) |-> debug_routed == $past(s_drst))
      else $error("debug routing did not follow the debug reset pin");
   // A system reset forces the drive enables off, so the edge after it is not checked.
   a_dbg_core_drive: assert property ($past(ce) && !$past(srst) && $past(s_drst)
      |-> dbg_pad_out == $past(dbg_core_out) && dbg_pad_oe_n == $past(dbg_core_oe_n))
      else $error("debug interface not driving its pins while routed");
   a_dbg_mux_owns: assert property ($past(ce) && !$past(s_drst) && $past(gpio_all)
      |-> dbg_pad_out == $past(dbg_gpio_out) && dbg_core_in == '1)
      else $error("pin mux not in control while debug reset asserted");
   a_dbg_no_leak: assert property ($past(ce) && !$past(s_drst) |-> dbg_core_in == '1)
      else $error("pins reached debug interface through the mux");
   a_rst_out_low: assert property (@(posedge clk) disable iff (por_srst)
      srst |=> rst_out_pad == 1'h0 && rst_out_oe_n == 1'h0)
      else $error("reset-out pad not driven low after system reset");
   a_battery_general_output_select: assert property ($past(ce) && !$past(srst)
      |-> battery_general_output_vbat_sel == $past(week_battery_general_output_sel))
      else $error("battery output selection does not follow week timer");
   a_baud_internal: assert property ($past(ce) && !$past(uart_ext_sel[0])
      && !$past(srst) |-> uart_baud_tick[0] == $past(uart_int_tick[0]))
      else $error("internal baud tick not passed through");
   a_mbox_merge: assert property ($past(ce) |-> merged_mailbox_irq_n == &$past(emi_irq_n))
      else $error("merged mailbox interrupt is wrong");
   a_strap_sample: assert property (@(posedge clk) disable iff (srst)
      $fell(por_srst) && ce |=> crisis_recovery == !$past(s_strap) ##1 $stable(crisis_recovery))
      else $error("recovery strap not sampled after power-on reset");
   a_ps2_idle: assert property ($past(ce) && !is_alt($past(ps2_a_mux_sel))
      && !is_alt($past(ps2_b_mux_sel)) |-> ps2_core_clk && ps2_pad_oe_n == 4'hF)
      else $error("unselected keyboard-mouse set reaches controller");
   a_tw_map: assert property ($past(ce) |-> tw_ctrl_sda_in[0] == $past(pick0))
      else $error("two-wire controller not fed from its mapped port");
   a_sci_fw: assert property ($past(ce) && !$past(srst) && $past(sci_fw_assert)
      |-> !controller_sci_n)
      else $error("firmware could not assert the SCI output");

   c_debug_takeover: cover property (!debug_routed ##1 ce [*3] ##1 debug_routed);
   c_crisis_entry: cover property (@(posedge clk) $fell(por_srst) ##1 crisis_recovery);
   c_ext_baud: cover property (uart_ext_sel[0] && uart_baud_tick[0]);
   c_mbox_irq: cover property (!merged_mailbox_irq_n);

endmodule : pfr_pin_function_routing

// ==== test/pfr_board.sv ====
`timescale 1ns/1ps
// Board side of the routing block: pulled-up open-drain lines and a debug probe.
module pfr_board (
   input  wire logic [3:0] dbg_pad_out,
   input  wire logic [3:0] dbg_pad_oe_n,
   input  wire logic [3:0] probe_pad,
   input  wire logic [3:0] ps2_pad_oe_n,
   input  wire logic [3:0] ps2_ext_low,
   input  wire logic [7:0] tw_sda_oe_n,
   input  wire logic [7:0] tw_scl_oe_n,
   input  wire logic [7:0] sda_ext_low,
   input  wire logic [7:0] scl_ext_low,
   output logic      [3:0] dbg_pad_in,
   output logic      [3:0] ps2_pad_in,
   output logic      [7:0] tw_sda_pad_in,
   output logic      [7:0] tw_scl_pad_in
);
   // A pad the device drives shows its value; a released pad shows the probe.
   assign dbg_pad_in = (~dbg_pad_oe_n & dbg_pad_out) | (dbg_pad_oe_n & probe_pad);
   // Released lines float up through the board pull-ups; either party may pull low.
   assign ps2_pad_in    = ps2_pad_oe_n & ~ps2_ext_low;
   assign tw_sda_pad_in = tw_sda_oe_n & ~sda_ext_low;
   assign tw_scl_pad_in = tw_scl_oe_n & ~scl_ext_low;
endmodule : pfr_board

// ==== test/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
   logic        clk = 1'h0, ce = 1'h1, srst = 1'h1, por_srst = 1'h1, debug_rst_n_pin;
   logic [3:0]  dbg_core_out, dbg_core_oe_n, dbg_gpio_out, dbg_gpio_oe_n, dbg_alt_out;
   logic [3:0]  dbg_alt_oe_n, probe, ps2_ext, dbg_pad_in, ps2_pad_in;
   logic [7:0]  dbg_mux_sel, sda_ext, scl_ext, tw_sda_pad_in, tw_scl_pad_in;
   logic [7:0]  tick_cnt = 8'h00, tick_base;
   logic [1:0]  ps2_a_mux_sel, ps2_b_mux_sel, uart_ext_sel, uart_int_tick, which;
   logic        ps2_clk_drive_low, ps2_dat_drive_low, rst_gpio_out, rst_gpio_oe_n;
   logic        week_battery_general_output_sel, battery_general_output_value, battery_general_output_gpio_out, uart_clk_pin, strap, wake_in;
   logic        cfg_power_protect, sci_hw_event, sci_fw_assert;
   logic [2:0]  emi_irq_n;
   logic [11:0] tw_port_sel;
   logic [3:0]  tw_sda_drive_low, tw_scl_drive_low;
   logic        debug_routed, ps2_core_clk, ps2_core_dat, rst_out_pad, rst_out_oe_n, battery_general_output_pad;
   logic        battery_general_output_vbat_sel, merged_mailbox_irq_n, crisis_recovery, wake_core_n;
   logic        uart_vcc_protect, controller_sci_n;
   logic [3:0]  dbg_pad_out, dbg_pad_oe_n, dbg_core_in, ps2_pad_out, ps2_pad_oe_n;
   logic [3:0]  tw_ctrl_sda_in, tw_ctrl_scl_in;
   logic [1:0]  uart_baud_tick;
   logic [7:0]  tw_pad_out, tw_sda_oe_n, tw_scl_oe_n;
   int          error_cnt = 0, checks_done = 0, cyc = 0;

   pfr_pin_function_routing dut (.clk(clk), .ce(ce), .srst(srst), .por_srst(por_srst),
      .debug_rst_n_pin(debug_rst_n_pin), .dbg_pad_in(dbg_pad_in), .dbg_core_out(dbg_core_out),
      .dbg_core_oe_n(dbg_core_oe_n), .dbg_gpio_out(dbg_gpio_out), .dbg_gpio_oe_n(dbg_gpio_oe_n),
      .dbg_alt_out(dbg_alt_out), .dbg_alt_oe_n(dbg_alt_oe_n), .dbg_mux_sel(dbg_mux_sel),
      .ps2_pad_in(ps2_pad_in), .ps2_a_mux_sel(ps2_a_mux_sel), .ps2_b_mux_sel(ps2_b_mux_sel),
      .ps2_clk_drive_low(ps2_clk_drive_low), .ps2_dat_drive_low(ps2_dat_drive_low),
      .rst_gpio_out(rst_gpio_out), .rst_gpio_oe_n(rst_gpio_oe_n), .week_battery_general_output_sel(week_battery_general_output_sel),
      .battery_general_output_value(battery_general_output_value), .battery_general_output_gpio_out(battery_general_output_gpio_out), .uart_clk_pin(uart_clk_pin),
      .uart_ext_sel(uart_ext_sel), .uart_int_tick(uart_int_tick), .emi_irq_n(emi_irq_n),
      .keyscan_recovery_strap(strap), .wake_input_n(wake_in), .tw_sda_pad_in(tw_sda_pad_in),
      .tw_scl_pad_in(tw_scl_pad_in), .tw_port_sel(tw_port_sel),
      .tw_sda_drive_low(tw_sda_drive_low), .tw_scl_drive_low(tw_scl_drive_low),
      .cfg_power_protect(cfg_power_protect), .sci_hw_event(sci_hw_event),
      .sci_fw_assert(sci_fw_assert), .debug_routed(debug_routed), .dbg_pad_out(dbg_pad_out),
      .dbg_pad_oe_n(dbg_pad_oe_n), .dbg_core_in(dbg_core_in), .ps2_pad_out(ps2_pad_out),
      .ps2_pad_oe_n(ps2_pad_oe_n), .ps2_core_clk(ps2_core_clk), .ps2_core_dat(ps2_core_dat),
      .rst_out_pad(rst_out_pad), .rst_out_oe_n(rst_out_oe_n), .battery_general_output_pad(battery_general_output_pad),
      .battery_general_output_vbat_sel(battery_general_output_vbat_sel), .uart_baud_tick(uart_baud_tick),
      .merged_mailbox_irq_n(merged_mailbox_irq_n), .crisis_recovery(crisis_recovery),
      .wake_core_n(wake_core_n), .tw_ctrl_sda_in(tw_ctrl_sda_in),
      .tw_ctrl_scl_in(tw_ctrl_scl_in), .tw_pad_out(tw_pad_out), .tw_sda_oe_n(tw_sda_oe_n),
      .tw_scl_oe_n(tw_scl_oe_n), .uart_vcc_protect(uart_vcc_protect),
      .controller_sci_n(controller_sci_n));

   pfr_board board (.dbg_pad_out(dbg_pad_out), .dbg_pad_oe_n(dbg_pad_oe_n), .probe_pad(probe),
      .ps2_pad_oe_n(ps2_pad_oe_n), .ps2_ext_low(ps2_ext), .tw_sda_oe_n(tw_sda_oe_n),
      .tw_scl_oe_n(tw_scl_oe_n), .sda_ext_low(sda_ext), .scl_ext_low(scl_ext),
      .dbg_pad_in(dbg_pad_in), .ps2_pad_in(ps2_pad_in), .tw_sda_pad_in(tw_sda_pad_in),
      .tw_scl_pad_in(tw_scl_pad_in));

   // Clock, hang guard and the external baud pulse counter sampled mid-cycle.
   always #20 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         results();
      end
   end
   always @(negedge clk) tick_cnt <= tick_cnt + {7'h00, uart_baud_tick[0]};

   task automatic results();
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : results

   task automatic chk(logic [15:0] got, logic [15:0] exp, string what);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   // Expected debug pad drive, drive enable and core view of the pads.
   function automatic logic [11:0] dbg_exp();
      logic [3:0] o, e, ci;
      for (int i = 0; i < 4; i++) begin
         case (dbg_mux_sel[2*i+:2])
            2'h0: begin o[i] = dbg_gpio_out[i]; e[i] = dbg_gpio_oe_n[i]; end
            2'h1: begin o[i] = dbg_alt_out[i]; e[i] = dbg_alt_oe_n[i]; end
            default: begin o[i] = 1'h0; e[i] = 1'h1; end
         endcase
      end
      ci = 4'hF;
      if (debug_rst_n_pin) begin
         o  = dbg_core_out;
         e  = dbg_core_oe_n;
         ci = (~e & o) | (e & probe);
      end
      return {o, e, ci};
   endfunction : dbg_exp

   // Pulls on a port are ORed over the controllers that select it.
   function automatic logic [11:0] tw_exp(logic [3:0] drv, logic [7:0] ext);
      logic [7:0] pull;
      logic [3:0] rd;
      pull = 8'h00;
      for (int c = 0; c < 4; c++) if (drv[c]) pull[tw_port_sel[c*3+:3]] = 1'h1;
      for (int c = 0; c < 4; c++) rd[c] = ~(pull[tw_port_sel[c*3+:3]] | ext[tw_port_sel[c*3+:3]]);
      return {rd, ~pull};
   endfunction : tw_exp

   task automatic check_all();
      logic [11:0] t;
      logic [3:0]  po, pp;
      logic        a, b;
      t = dbg_exp();
      a = (which == 2'h1);
      b = (which == 2'h2);
      po = ~{b & ps2_dat_drive_low, b & ps2_clk_drive_low, a & ps2_dat_drive_low,
             a & ps2_clk_drive_low};
      pp = po & ~ps2_ext;
      chk(debug_routed, debug_rst_n_pin, "routed");
      chk({dbg_pad_out, dbg_pad_oe_n, dbg_core_in}, t, "debug pins");
      chk(ps2_pad_oe_n, po, "ps2 oe");
      chk({ps2_pad_out, ps2_core_clk, ps2_core_dat}, {4'h0, a ? pp[0] : b ? pp[2] : 1'h1,
          a ? pp[1] : b ? pp[3] : 1'h1}, "ps2 core");
      chk({rst_out_pad, rst_out_oe_n}, {rst_gpio_out, rst_gpio_oe_n}, "rst out");
      chk({battery_general_output_pad, battery_general_output_vbat_sel}, {week_battery_general_output_sel ? battery_general_output_value : battery_general_output_gpio_out,
          week_battery_general_output_sel}, "battery_general_output");
      chk(uart_baud_tick, ~uart_ext_sel & uart_int_tick, "baud");
      chk(merged_mailbox_irq_n, &emi_irq_n, "mailbox");
      chk(wake_core_n, wake_in, "wake");
      chk({tw_ctrl_sda_in, tw_sda_oe_n}, tw_exp(tw_sda_drive_low, sda_ext), "sda");
      chk({tw_ctrl_scl_in, tw_scl_oe_n}, tw_exp(tw_scl_drive_low, scl_ext), "scl");
      chk(tw_pad_out, 8'h00, "tw out");
      chk(uart_vcc_protect, cfg_power_protect, "vcc protect");
      // Logical not keeps the expectation one bit wide inside the wider compare argument.
      chk(controller_sci_n, !(sci_hw_event | sci_fw_assert), "sci");
   endtask : check_all

   // Low bits of the trial index sweep the corner combinations first.
   task automatic rand_in(int i);
      {dbg_core_out, dbg_core_oe_n, dbg_gpio_out, dbg_gpio_oe_n} = 16'($urandom);
      {dbg_alt_out, dbg_alt_oe_n, probe, dbg_mux_sel, ps2_ext} = 24'($urandom);
      {sda_ext, scl_ext, tw_port_sel, tw_sda_drive_low} = $urandom;
      {tw_scl_drive_low, ps2_clk_drive_low, ps2_dat_drive_low, rst_gpio_out} = 7'($urandom);
      {rst_gpio_oe_n, battery_general_output_value, battery_general_output_gpio_out, wake_in, cfg_power_protect} = 5'($urandom);
      {uart_ext_sel, uart_int_tick, week_battery_general_output_sel} = 5'($urandom);
      debug_rst_n_pin = i[0];
      {emi_irq_n, sci_hw_event, sci_fw_assert} = (i < 32) ? i[4:0] : 5'($urandom);
      // The first trials hand every debug pin to its GPIO function.
      if (i < 8) dbg_mux_sel = 8'h00;
      which = 2'(i % 3);
      // Only one keyboard-mouse set is steered to the controller at a time.
      ps2_a_mux_sel = (which == 2'h1) ? 2'h1 : 2'h2 | 2'($urandom);
      ps2_b_mux_sel = (which == 2'h2) ? 2'h1 : 2'h0;
   endtask : rand_in

   task automatic waitn(int n);
      repeat (n) @(negedge clk);
   endtask : waitn

   initial begin
      void'($urandom(96959));
      strap = 1'h1;
      uart_clk_pin = 1'h0;
      rand_in(0);
      rst_gpio_out = 1'h1;
      rst_gpio_oe_n = 1'h1;
      waitn(8);
      chk({rst_out_pad, rst_out_oe_n, battery_general_output_vbat_sel, controller_sci_n}, 4'h1, "reset");
      chk({ps2_pad_oe_n, tw_sda_oe_n, uart_baud_tick}, 14'h3FFC, "reset oe");
      srst = 1'h0;
      por_srst = 1'h0;
      waitn(2);
      chk(crisis_recovery, 1'h0, "strap high");
      for (int i = 0; i < 120; i++) begin
         rand_in(i);
         waitn(7);
         check_all();
      end
      // External baud clock: five rising edges give five ticks on the port that picks it.
      uart_ext_sel = 2'h1;
      uart_int_tick = 2'h0;
      waitn(4);
      // The counter has one driver; the scenario measures from a snapshot instead.
      tick_base = tick_cnt;
      repeat (5) begin
         uart_clk_pin = 1'h1;
         waitn(3);
         uart_clk_pin = 1'h0;
         waitn(3);
      end
      waitn(4);
      chk(8'(tick_cnt - tick_base), 8'h05, "ext ticks");
      // A low clock enable freezes every flop, so the output keeps its old level.
      ce = 1'h0;
      cfg_power_protect = !cfg_power_protect;
      waitn(3);
      chk(uart_vcc_protect, !cfg_power_protect, "frozen");
      ce = 1'h1;
      waitn(2);
      chk(uart_vcc_protect, cfg_power_protect, "thawed");
      // Strap low through power-on reset; a later system reset keeps the flag.
      strap = 1'h0;
      waitn(4);
      por_srst = 1'h1;
      waitn(4);
      por_srst = 1'h0;
      waitn(2);
      chk(crisis_recovery, 1'h1, "strap low");
      srst = 1'h1;
      waitn(4);
      srst = 1'h0;
      waitn(2);
      chk(crisis_recovery, 1'h1, "flag kept");
      results();
   end
endmodule : tb_top
